// >>> dv/mps_pin_select_asserts.sv
// timing checks on the pin select ports
`timescale 1ns/1ps
`default_nettype none
module mps_pin_select_asserts (
    input wire logic       sys_clk_i,
    input wire logic       sys_rst_i,
    input wire logic [2:0] out_sel_i,
    input wire logic       rts_assert_i,
    input wire logic       rts_negate_i,
    input wire logic       tx_auto_rts_i,
    input wire logic       rx_flow_rts_i,
    input wire logic       tx_shift_done_i,
    input wire logic       tx_holding_empty_i,
    input wire logic       rx_fifo_full_i,
    input wire logic       rx_shift_full_i,
    input wire logic       multi_output_pin_o,
    input wire logic       multi_output_pin_oe_o,
    input wire logic       general_input_o,
    input wire logic       rx_sample_o,
    input wire logic       tx_shift_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // no command this cycle, pin carrying request-to-send
    sequence s_quiet; !rts_assert_i && !rts_negate_i && out_sel_i == 3'h0; endsequence
    sequence s_rel; ##2 multi_output_pin_o; endsequence
    property p_rts_on;
        rts_assert_i && !rts_negate_i && out_sel_i == 3'h0 |-> ##2 !multi_output_pin_o;
    endproperty
    property p_rts_off; rts_negate_i && out_sel_i == 3'h0 |-> s_rel; endproperty
    property p_tx_auto; s_quiet ##0 (tx_auto_rts_i && tx_shift_done_i) |-> s_rel; endproperty
    property p_rx_flow;
        s_quiet ##0 (rx_flow_rts_i && rx_fifo_full_i && rx_shift_full_i) |-> s_rel;
    endproperty
    property p_tx_holding_empty_n;
        $past(out_sel_i, 2) == 3'h6 |->
            multi_output_pin_oe_o == $past(tx_holding_empty_i) && !multi_output_pin_o;
    endproperty
    property p_drive; $past(out_sel_i, 2) < 3'h6 |-> multi_output_pin_oe_o; endproperty
    property p_rxs; rx_sample_o |-> general_input_o && !$past(general_input_o); endproperty
    property p_txs; tx_shift_o |-> !general_input_o && $past(general_input_o); endproperty
    a_rts_on: assert property (p_rts_on) else $error("rts not asserted");
    a_rts_off: assert property (p_rts_off) else $error("rts not released");
    a_tx_auto: assert property (p_tx_auto) else $error("no tx auto release");
    a_rx_flow: assert property (p_rx_flow) else $error("no rx flow release");
    a_tx_holding_empty_n: assert property (p_tx_holding_empty_n) else $error("tx ready pin wrong");
    a_drive: assert property (p_drive) else $error("pin not driven");
    a_rxs: assert property (p_rxs) else $error("rx sample off rise");
    a_txs: assert property (p_txs) else $error("tx shift off fall");
endmodule
bind mps_pin_select mps_pin_select_asserts u_chk (
    .sys_clk_i             (sys_clk_i),
    .sys_rst_i             (sys_rst_i),
    .out_sel_i             (out_sel_i),
    .rts_assert_i          (rts_assert_i),
    .rts_negate_i          (rts_negate_i),
    .tx_auto_rts_i         (tx_auto_rts_i),
    .rx_flow_rts_i         (rx_flow_rts_i),
    .tx_shift_done_i       (tx_shift_done_i),
    .tx_holding_empty_i    (tx_holding_empty_i),
    .rx_fifo_full_i        (rx_fifo_full_i),
    .rx_shift_full_i       (rx_shift_full_i),
    .multi_output_pin_o    (multi_output_pin_o),
    .multi_output_pin_oe_o (multi_output_pin_oe_o),
    .general_input_o       (general_input_o),
    .rx_sample_o           (rx_sample_o),
    .tx_shift_o            (tx_shift_o)
);
`default_nettype wire

// >>> dv/mps_remote.sv
// remote equipment model driving the multipurpose input pin
`timescale 1ns/1ps
`default_nettype none
module mps_remote (
    input  wire logic sys_clk_i,
    output var  logic pin_o
);
    // idle high, like the pin's own pull-up
    initial pin_o = 1'h1;
    // low allows sending, high holds the sender off
    task automatic level(input logic v);
        @(negedge sys_clk_i) pin_o = v;
    endtask
    // clock bursts, still between them; four cycles a phase beats the filter
    task automatic burst(input int n);
        repeat (n) begin
            level(1'h0);
            repeat (3) @(negedge sys_clk_i);
            level(1'h1);
            repeat (3) @(negedge sys_clk_i);
        end
    endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the multipurpose pin select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk = 1'h0, rst = 1'h1, ra = 1'h0, rn = 1'h0, sd = 1'h0, ta = 1'h0;
    logic       rf = 1'h0, fl = 1'h0, he = 1'h0, ne = 1'h0, ff = 1'h0, sf = 1'h0;
    logic [2:0] osel = 3'h0;
    logic [1:0] isel = 2'h0;
    logic [7:0] csb = 8'h00;
    logic [4:0] src = 5'h00;
    wire        multi_input_pin, multi_output_pin, oe, gi, cts, tk, rxe, rx16, rxs, txe, tx16, txs;
    wire        pw = oe ? multi_output_pin : 1'h1; // open drain with pull-up
    int         n_mismatch = 0, total_checks = 0, n_rx = 0, n_tx = 0, n_tk = 0;
    mps_remote u_rem (.sys_clk_i(clk), .pin_o(multi_input_pin));
    mps_pin_select u_dut (.sys_clk_i(clk), .sys_rst_i(rst), .out_sel_i(osel),
        .in_sel_i(isel), .clock_select_bits_i(csb), .rts_assert_i(ra), .rts_negate_i(rn),
        .tx_auto_rts_i(ta), .rx_flow_rts_i(rf), .rx_full_level_i(fl), .tx_shift_done_i(sd),
        .tx_holding_empty_i(he), .rx_fifo_not_empty_i(ne), .rx_fifo_full_i(ff),
        .rx_shift_full_i(sf), .counter_timer_out_i(src[0]), .tx_baud_clock_1x_i(src[1]),
        .tx_baud_clock_16x_i(src[2]), .rx_baud_clock_1x_i(src[3]),
        .rx_baud_clock_16x_i(src[4]), .multi_input_pin_i(multi_input_pin), .multi_output_pin_o(multi_output_pin),
        .multi_output_pin_oe_o(oe), .general_input_o(gi), .clear_to_send_n_o(cts),
        .timer_ext_tick_o(tk), .rx_ext_clk_en_o(rxe), .rx_ext_16x_o(rx16),
        .rx_sample_o(rxs), .tx_ext_clk_en_o(txe), .tx_ext_16x_o(tx16), .tx_shift_o(txs));
    always #2 clk = ~clk;
    // pulse counters; case equality keeps an unknown from counting
    always @(posedge clk) begin
        n_rx <= n_rx + (rxs === 1'h1);
        n_tx <= n_tx + (txs === 1'h1);
        n_tk <= n_tk + (tk === 1'h1);
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // one-cycle pulse of assert, negate, shift done, then let the pin settle
    task automatic cmd(input logic [2:0] v);
        {ra, rn, sd} = v;
        step(1);
        {ra, rn, sd} = 3'h0;
        step(2);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #4000;
        n_mismatch++;
        test_done;
    end
    initial begin
        step(10);
        rst = 1'h0;
        step(1);
        chk({multi_output_pin, oe, gi, cts}, 4'hE, "reset_outputs");
        cmd(3'h4); chk(multi_output_pin, 0, "rts");
        cmd(3'h6); chk(multi_output_pin, 1, "rts");
        cmd(3'h4); cmd(3'h1); chk(multi_output_pin, 0, "rts_no_auto");
        ta = 1'h1; cmd(3'h1); chk(multi_output_pin, 1, "rts_tx_auto");
        cmd(3'h4); {rf, ff, sf} = 3'h7; step(3); chk(multi_output_pin, 1, "rts_rx_flow");
        {rf, ff, sf} = 3'h0;
        $display("test rts done");
        for (int k = 1; k < 6; k++) begin
            osel = 3'(k); src = 5'h01 << (k - 1); step(3); chk(multi_output_pin, 1, "mux");
            src = ~src; step(2); chk({multi_output_pin, oe}, 2'h1, "mux");
        end
        osel = 3'h6; he = 1'h1; step(3); chk({pw, oe}, 2'h1, "tx_ready");
        he = 1'h0; step(2); chk({pw, oe}, 2'h2, "tx_ready");
        osel = 3'h7; ne = 1'h1; step(3); chk({pw, oe}, 2'h1, "rx_ready");
        ne = 1'h0; ff = 1'h1; step(2); chk(pw, 1, "rx_ready");
        fl = 1'h1; step(2); chk({pw, oe}, 2'h1, "rx_full");
        $display("test output select done");
        isel = 2'h1; u_rem.level(1'h0); step(7); chk({gi, cts}, 2'h0, "cts_low");
        u_rem.level(1'h1); step(7); chk({gi, cts}, 2'h3, "cts_high");
        isel = 2'h3; csb = 8'hFF; step(2); chk({rxe, rx16, txe, tx16}, 4'hA, "ext_1x");
        csb = 8'hEE; step(2); chk({rxe, rx16, txe, tx16}, 4'hF, "ext_16x");
        chk(n_rx + n_tx, 0, "idle_pulses");
        u_rem.burst(3); step(7); chk(n_rx, 32'h0000_0003, "rx_edges");
        chk(n_tx, 32'h0000_0003, "tx_edges");
        isel = 2'h2; u_rem.burst(2); step(7); chk(n_tk, 2, "timer_ticks");
        $display("test input select done");
        test_done;
    end
endmodule
`default_nettype wire

// >>> logic/mps_defines.vh
// constants for the multipurpose pin select block
`ifndef MPS_DEFINES_VH
`define MPS_DEFINES_VH
// output function select codes
`define MPS_OSEL_RTS        3'h0
`define MPS_OSEL_CT         3'h1
`define MPS_OSEL_TX1X       3'h2
`define MPS_OSEL_TX16X      3'h3
`define MPS_OSEL_RX1X       3'h4
`define MPS_OSEL_RX16X      3'h5
`define MPS_OSEL_TX_HOLDING_EMPTY_N      3'h6
`define MPS_OSEL_RXRDY      3'h7
// input function select codes
`define MPS_ISEL_GPI        2'h0
`define MPS_ISEL_CTS        2'h1
`define MPS_ISEL_TIMER_EXT_CLOCK      2'h2
`define MPS_ISEL_SERIAL_EXT_CLOCK      2'h3
// clock select field positions and external rate codes
`define MPS_CSR_RX_LSB      0
`define MPS_CSR_TX_LSB      4
`define MPS_CSR_EXT16X      4'hE
`define MPS_CSR_EXT1X       4'hF
// reset values
`define MPS_RST_OSEL        3'h0
`define MPS_RST_RTS_N       1'h1
`define MPS_RST_PIN         1'h1
`define MPS_RST_OE          1'h1
`define MPS_RST_GPI         1'h1
`define MPS_RST_CTS_N       1'h0
`endif

// >>> logic/mps_pin_select.v
// multipurpose output and input pin function select
// Summary of operation
// R1: exactly one selected function is routed to the output pin
// R2: request-to-send follows assert and negate commands
// R3: transmit auto mode releases request-to-send when transmitter empties
// R4: receive flow mode releases request-to-send when fifo and shifter full
// R5: output can carry timer output or tx/rx 1x or 16x clocks
// R6: transmit-ready pulls pin low while holding register empty, open drain
// R7: receive-ready pulls low on fifo not empty or full, open drain
// R8: input pin level is readable as general input status bit
// R9: remote drives clear-to-send low to allow transmission
// R10: input pin can clock the counter/timer
// R11: external serial clock is 1x or 16x per clock select nibbles
// R12: external receive clock samples serial input on rising edge
// R13: external transmit clock changes serial output on falling edge
// R14: new output selection reaches pin within few cycles, glitch free
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.vh"
module mps_pin_select (
    input  wire       sys_clk_i,
    input  wire       sys_rst_i,
    input  wire [2:0] out_sel_i,        // auxiliary control output select
    input  wire [1:0] in_sel_i,         // auxiliary control input select
    input  wire [7:0] clock_select_bits_i,
    input  wire       rts_assert_i,     // command pulse
    input  wire       rts_negate_i,     // command pulse
    input  wire       tx_auto_rts_i,    // mode: release after transmit done
    input  wire       rx_flow_rts_i,    // mode: release on receive full
    input  wire       rx_full_level_i,  // 1: ready flag means fifo full
    input  wire       tx_shift_done_i,  // pulse: character fully shifted
    input  wire       tx_holding_empty_i,
    input  wire       rx_fifo_not_empty_i,
    input  wire       rx_fifo_full_i,
    input  wire       rx_shift_full_i,
    input  wire       counter_timer_out_i,
    input  wire       tx_baud_clock_1x_i,
    input  wire       tx_baud_clock_16x_i,
    input  wire       rx_baud_clock_1x_i,
    input  wire       rx_baud_clock_16x_i,
    input  wire       multi_input_pin_i,
    output reg        multi_output_pin_o,
    output reg        multi_output_pin_oe_o,
    output reg        general_input_o,
    output reg        clear_to_send_n_o,
    output reg        timer_ext_tick_o,
    output reg        rx_ext_clk_en_o,
    output reg        rx_ext_16x_o,
    output reg        rx_sample_o,
    output reg        tx_ext_clk_en_o,
    output reg        tx_ext_16x_o,
    output reg        tx_shift_o
);
    // synchronised view of the input pin
    wire       pin_lvl;
    wire       pin_rise;
    wire       pin_fall;
    // request-to-send flop and its next value
    reg        request_to_send_n_r;
    reg        rts_n_nxt;
    // registered output select and next pin drive
    reg  [2:0] sel_r;
    reg        pin_nxt;
    reg        oe_nxt;
    // next values of the input-side outputs
    reg        gpi_nxt;
    reg        cts_n_nxt;
    reg        tick_nxt;
    reg        rx_en_nxt;
    reg        rx_16x_nxt;
    reg        rx_smp_nxt;
    reg        tx_en_nxt;
    reg        tx_16x_nxt;
    reg        tx_shf_nxt;
    // decoded clock select nibbles
    wire [3:0] rx_code;
    wire [3:0] tx_code;

    // is a clock select nibble an external clock code
    function is_ext;
        input [3:0] code;
        begin
            is_ext = (code == `MPS_CSR_EXT16X) || (code == `MPS_CSR_EXT1X);
        end
    endfunction

    // input pin is an external serial clock for the given direction
    function ext_clk;
        input [1:0] isel;
        input [3:0] code;
        begin
            ext_clk = (isel == `MPS_ISEL_SERIAL_EXT_CLOCK) && is_ext(code);
        end
    endfunction

    // receive and transmit rate nibbles of the clock select byte
    assign rx_code = clock_select_bits_i[`MPS_CSR_RX_LSB +: 4];
    assign tx_code = clock_select_bits_i[`MPS_CSR_TX_LSB +: 4];

    // pin level passes four flops (three stages and the filter output) before any function sees it
    mps_sync3 u_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (multi_input_pin_i),
        .level_o   (pin_lvl),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    // request-to-send next value; negate beats assert, commands beat auto releases
    always @* begin
        rts_n_nxt = request_to_send_n_r;
        if (rts_negate_i) begin
            rts_n_nxt = 1'b1;                                    // see R2
        end else if (rts_assert_i) begin
            rts_n_nxt = 1'b0;                                    // see R2
        end else if (tx_auto_rts_i && tx_shift_done_i) begin
            rts_n_nxt = 1'b1;                                    // see R3
        end else if (rx_flow_rts_i && rx_fifo_full_i && rx_shift_full_i) begin
            // both receive stages hold data; releasing stops the remote sender
            rts_n_nxt = 1'b1;                                    // see R4
        end
    end

    // request-to-send flop; released (high) out of reset
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            request_to_send_n_r <= `MPS_RST_RTS_N;
        end else begin
            request_to_send_n_r <= rts_n_nxt;
        end
    end

    // output mux; selection registered once so a change lands cleanly
    // open-drain codes drive a constant low and steer only the enable,
    // so the pin never shows a driven high while it should be released
    always @* begin
        pin_nxt = 1'b1;
        oe_nxt  = 1'b1;
        case (sel_r)                                             // see R1
            `MPS_OSEL_RTS:   pin_nxt = request_to_send_n_r;      // see R2
            `MPS_OSEL_CT:    pin_nxt = counter_timer_out_i;      // see R5
            `MPS_OSEL_TX1X:  pin_nxt = tx_baud_clock_1x_i;       // see R5
            `MPS_OSEL_TX16X: pin_nxt = tx_baud_clock_16x_i;      // see R5
            `MPS_OSEL_RX1X:  pin_nxt = rx_baud_clock_1x_i;       // see R5
            `MPS_OSEL_RX16X: pin_nxt = rx_baud_clock_16x_i;      // see R5
            `MPS_OSEL_TX_HOLDING_EMPTY_N: begin
                pin_nxt = 1'b0;
                oe_nxt  = tx_holding_empty_i;                    // see R6
            end
            `MPS_OSEL_RXRDY: begin
                pin_nxt = 1'b0;
                oe_nxt  = rx_full_level_i ? rx_fifo_full_i
                                          : rx_fifo_not_empty_i; // see R7
            end
            default: begin
                pin_nxt = 1'b1;
                oe_nxt  = 1'b1;
            end
        endcase
    end

    // registered pin drive; two-cycle select latency, no partial-cycle glitch
    // trade-off: one extra cycle of latency buys a pin that never shows a mux race
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sel_r                 <= `MPS_RST_OSEL;
            multi_output_pin_o    <= `MPS_RST_PIN;
            multi_output_pin_oe_o <= `MPS_RST_OE;
        end else begin
            sel_r                 <= out_sel_i;                  // see R14
            multi_output_pin_o    <= pin_nxt;                    // see R14
            multi_output_pin_oe_o <= oe_nxt;
        end
    end

    // input pin functions; the pin level always feeds the status bit
    always @* begin
        gpi_nxt    = pin_lvl;                                    // see R8
        // cts reads low (allowed) unless the pin serves as cts, so a spare pin never stalls
        cts_n_nxt  = 1'b0;
        tick_nxt   = 1'b0;
        rx_en_nxt  = ext_clk(in_sel_i, rx_code);                 // see R11
        rx_16x_nxt = (rx_code == `MPS_CSR_EXT16X);               // see R11
        tx_en_nxt  = ext_clk(in_sel_i, tx_code);                 // see R11
        tx_16x_nxt = (tx_code == `MPS_CSR_EXT16X);               // see R11
        // receive samples on the synchronised rising edge only
        rx_smp_nxt = rx_en_nxt && pin_rise;                      // see R12
        // transmit shifts on the synchronised falling edge only
        tx_shf_nxt = tx_en_nxt && pin_fall;                      // see R13
        case (in_sel_i)
            `MPS_ISEL_CTS:   cts_n_nxt = pin_lvl;                // see R9
            `MPS_ISEL_TIMER_EXT_CLOCK: tick_nxt  = pin_rise;               // see R10
            default: begin
                cts_n_nxt = 1'b0;
                tick_nxt  = 1'b0;
            end
        endcase
    end

    // input-side outputs registered; edge ticks last exactly one cycle
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            general_input_o   <= `MPS_RST_GPI;
            clear_to_send_n_o <= `MPS_RST_CTS_N;
            timer_ext_tick_o  <= 1'b0;
            rx_ext_clk_en_o   <= 1'b0;
            rx_ext_16x_o      <= 1'b0;
            rx_sample_o       <= 1'b0;
            tx_ext_clk_en_o   <= 1'b0;
            tx_ext_16x_o      <= 1'b0;
            tx_shift_o        <= 1'b0;
        end else begin
            general_input_o   <= gpi_nxt;
            clear_to_send_n_o <= cts_n_nxt;
            timer_ext_tick_o  <= tick_nxt;
            rx_ext_clk_en_o   <= rx_en_nxt;
            rx_ext_16x_o      <= rx_16x_nxt;
            rx_sample_o       <= rx_smp_nxt;
            tx_ext_clk_en_o   <= tx_en_nxt;
            tx_ext_16x_o      <= tx_16x_nxt;
            tx_shift_o        <= tx_shf_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> logic/mps_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mps_sync3 (
    input  wire sys_clk_i,
    input  wire sys_rst_i,
    input  wire async_i,
    output reg  level_o,
    output reg  rise_o,
    output reg  fall_o
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // first stage feeds only the second; level changes once stages two and three agree
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s1_r    <= 1'b1;
            s2_r    <= 1'b1;
            s3_r    <= 1'b1;
            level_o <= 1'b1;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            s1_r   <= async_i;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (s2_r == s3_r && s3_r != level_o) begin
                level_o <= s3_r;
                rise_o  <= s3_r;
                fall_o  <= ~s3_r;
            end
        end
    end
endmodule
`default_nettype wire
